/* design/servo_speed_cap_select.sv */
// Speed cap selection, full-closed mode guard and APB register file
//
// Chosen here: the register addresses and the APB register port.
module servo_speed_cap_select
   import servo_cap_pkg::*;
#(
   parameter logic [15:0] INTERNAL_OVS = 16'h4e20, // Internal overspeed protection level
   parameter int unsigned KP_SHIFT     = 4         // Regulator gain shift
) (
   input  wire logic                                   clk,
   input  wire logic                                   rst_b,
   input  wire servo_cap_pkg::apb_req_t                apbReq,
   output      logic        [servo_cap_pkg::DATA_W-1:0] prdata,
   output      logic                                   pready,
   output      logic                                   pslverr,
   input  wire logic                                   cmdValid,
   input  wire logic        [7:0]                      cmdCode,
   input  wire logic                                   speed_limit_switch_cmd,
   input  wire logic signed [servo_cap_pkg::SPEED_W-1:0] hostTorque,
   input  wire logic signed [servo_cap_pkg::SPEED_W-1:0] motorSpeed,
   input  wire logic        [31:0]                     motorPosition,
   input  wire logic        [31:0]                     scalePosition,
   input  wire logic        [31:0]                     positionCommand,
   output      logic signed [servo_cap_pkg::SPEED_W-1:0] motorTorque,
   output      logic signed [servo_cap_pkg::SPEED_W-1:0] velocityFeedback,
   output      logic        [31:0]                     positionFeedback,
   output      logic        [31:0]                     positionReference,
   output      servo_cap_pkg::ctrl_mode_t              controlMode,
   output      logic                                   command_fault,
   output      logic        [15:0]                     faultCode,
   output      logic                                   capActive,
   output      logic        [servo_cap_pkg::SPEED_W-1:0] appliedCap
);
   import servo_cap_pkg::*;

   // Overspeed level must be a legal cap
   if (INTERNAL_OVS > CAP_MAX) begin : ovsCheck
      $error("INTERNAL_OVS above cap range");
   end

   // Whole block state
   typedef struct packed {
      logic               limit_source_select;   // Cap source selection
      logic               fullClosedEnable;      // Full-closed loop requested
      logic [SPEED_W-1:0] speed_cap_one;         // First cap setting
      logic [SPEED_W-1:0] speed_cap_two;         // Second cap setting
      logic [SPEED_W-1:0] overspeed_threshold;   // First overspeed level
      logic [SPEED_W-1:0] second_overspeed_threshold; // Second overspeed level
      ctrl_mode_t         mode;                  // Current control mode
      logic               fault;                 // Sticky command fault
      logic               active;                // Cap regulator engaged
      logic [SPEED_W-1:0] cap;                   // Applied cap
      logic [DATA_W-1:0]  rdata;                 // Read data latched in setup
      logic signed [SPEED_W-1:0] velFb;          // Velocity feedback
      logic [31:0]        posFb;                 // Position feedback
      logic [31:0]        posRef;                // Position reference
   } blk_state_t;

   logic [1:0]         rstPipe;                  // Reset release synchroniser
   logic               rstSyncB;                 // Synchronised reset
   blk_state_t         state;                    // Registered state
   blk_state_t         next_state;               // Next state
   logic               setupPhase;               // APB setup cycle
   logic               accessPhase;              // APB access cycle
   logic [SPEED_W-1:0] selectedCap;              // Cap chosen by source
   logic               fullClosedActive;         // Full-closed loop running
   logic               isTorqueMode;             // Torque control selected

   // Smaller of two speeds
   function automatic logic [SPEED_W-1:0] minSpeed(input logic [SPEED_W-1:0] a, input logic [SPEED_W-1:0] b);
      return (a < b) ? a : b;
   endfunction

   // Clamp a written cap to the legal range
   function automatic logic [SPEED_W-1:0] capClamp(input logic [DATA_W-1:0] w);
      return (w > DATA_W'(CAP_MAX)) ? CAP_MAX : w[SPEED_W-1:0];
   endfunction

   // Decode of mapped offsets
   function automatic logic isMapped(input logic [ADDR_W-1:0] a);
      return (a == OFS_CONTROL) || (a == OFS_CAP_ONE) || (a == OFS_CAP_TWO) || (a == OFS_OVS_ONE)
             || (a == OFS_OVS_TWO) || (a == OFS_STATUS) || (a == OFS_FAULT);
   endfunction

   // Reset release through two flops
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rstPipe <= 2'h0;
      end else begin
         rstPipe <= {rstPipe[0], 1'b1};
      end
   end
   assign rstSyncB = rstPipe[1];

   // Bus phases and handshake
   assign setupPhase  = apbReq.psel && !apbReq.penable;
   assign accessPhase = apbReq.psel && apbReq.penable;
   assign pready      = accessPhase;
   assign pslverr     = accessPhase && !isMapped(apbReq.paddr);

   // Cap source and full-closed qualification
   always_comb begin
      if (state.limit_source_select && speed_limit_switch_cmd) begin
         selectedCap = state.speed_cap_two;
      end else begin
         selectedCap = state.speed_cap_one;
      end
      fullClosedActive = state.fullClosedEnable
                         && ((state.mode == MODE_PROFILE_POS) || (state.mode == MODE_CYCLIC_POS));
      isTorqueMode = (state.mode == MODE_CYCLIC_TRQ);
   end

   // Next-state logic
   always_comb begin
      next_state = state;

      // Applied cap is the smallest limit
      next_state.cap = minSpeed(minSpeed(selectedCap, state.overspeed_threshold),
                                minSpeed(state.second_overspeed_threshold, INTERNAL_OVS));
      // Engage regulator when speed magnitude reaches cap
      next_state.active = isTorqueMode && (speedMagnitude(motorSpeed) >= state.cap);

      // Feedback routing
      next_state.velFb  = motorSpeed;
      next_state.posFb  = fullClosedActive ? scalePosition : motorPosition;
      next_state.posRef = positionCommand;

      // Read data captured in the setup cycle
      if (setupPhase) begin
         next_state.rdata = '0;
         case (apbReq.paddr)
            OFS_CONTROL: begin
               next_state.rdata[CTRL_SOURCE_BIT] = state.limit_source_select;
               next_state.rdata[CTRL_FCLOSE_BIT] = state.fullClosedEnable;
            end
            OFS_CAP_ONE: next_state.rdata[SPEED_W-1:0] = state.speed_cap_one;
            OFS_CAP_TWO: next_state.rdata[SPEED_W-1:0] = state.speed_cap_two;
            OFS_OVS_ONE: next_state.rdata[SPEED_W-1:0] = state.overspeed_threshold;
            OFS_OVS_TWO: next_state.rdata[SPEED_W-1:0] = state.second_overspeed_threshold;
            OFS_STATUS: begin
               next_state.rdata[STAT_FAULT_BIT]  = state.fault;
               next_state.rdata[STAT_ACTIVE_BIT] = state.active;
               next_state.rdata[STAT_FCLOSE_BIT] = fullClosedActive;
               next_state.rdata[STAT_MODE_LSB +: 3] = state.mode;
               next_state.rdata[STAT_CAP_LSB +: SPEED_W] = state.cap;
            end
            OFS_FAULT: next_state.rdata[15:0] = state.fault ? {FAULT_MAIN, FAULT_SUB, FAULT_DETAIL} : 16'h0000;
            default: next_state.rdata = '0;   // Unmapped reads zero
         endcase
      end

      // Register writes at the access edge
      if (accessPhase && apbReq.pwrite) begin
         case (apbReq.paddr)
            OFS_CONTROL: begin
               next_state.limit_source_select = apbReq.pwdata[CTRL_SOURCE_BIT];
               next_state.fullClosedEnable    = apbReq.pwdata[CTRL_FCLOSE_BIT];
            end
            OFS_CAP_ONE: next_state.speed_cap_one = capClamp(apbReq.pwdata);
            OFS_CAP_TWO: next_state.speed_cap_two = capClamp(apbReq.pwdata);
            OFS_OVS_ONE: next_state.overspeed_threshold = capClamp(apbReq.pwdata);
            OFS_OVS_TWO: next_state.second_overspeed_threshold = capClamp(apbReq.pwdata);
            OFS_STATUS: begin
               // Write one clears the fault
               if (apbReq.pwdata[STAT_FAULT_BIT]) begin
                  next_state.fault = 1'b0;
               end
            end
            default: begin
               // Read-only or unmapped: no effect
            end
         endcase
      end

      // Cyclic command decode; a new fault outranks a clear
      if (cmdValid) begin
         case (cmdCode[7:4])
            CODE_PP: next_state.mode = MODE_PROFILE_POS;
            CODE_CP: next_state.mode = MODE_CYCLIC_POS;
            CODE_CV: begin
               if (state.fullClosedEnable) begin
                  next_state.fault = 1'b1;
               end else begin
                  next_state.mode = MODE_CYCLIC_VEL;
               end
            end
            CODE_CT: begin
               if (state.fullClosedEnable) begin
                  next_state.fault = 1'b1;
               end else begin
                  next_state.mode = MODE_CYCLIC_TRQ;
               end
            end
            default: begin
               // Other codes leave the mode alone
            end
         endcase
      end
   end

   // State register
   always_ff @(posedge clk or negedge rstSyncB) begin
      if (!rstSyncB) begin
         state <= '{limit_source_select: 1'b0, fullClosedEnable: 1'b0,
                    speed_cap_one: CAP_RESET, speed_cap_two: CAP_RESET,
                    overspeed_threshold: OVS_RESET, second_overspeed_threshold: OVS_RESET,
                    mode: MODE_IDLE, fault: 1'b0, active: 1'b0, cap: CAP_RESET,
                    rdata: '0, velFb: '0, posFb: '0, posRef: '0};
      end else begin
         state <= next_state;
      end
   end

   // Torque override regulator
   speed_cap_regulator #(
      .KP_SHIFT   (KP_SHIFT)
   ) regulator (
      .clk        (clk),
      .rstSyncB   (rstSyncB),
      .capActive  (state.active),
      .cap        (state.cap),
      .motorSpeed (motorSpeed),
      .hostTorque (hostTorque),
      .motorTorque(motorTorque)
   );

   // Outputs from state
   assign prdata            = state.rdata;
   assign velocityFeedback  = state.velFb;
   assign positionFeedback  = state.posFb;
   assign positionReference = state.posRef;
   assign controlMode       = state.mode;
   assign command_fault     = state.fault;
   assign faultCode         = state.fault ? {FAULT_MAIN, FAULT_SUB, FAULT_DETAIL} : 16'h0000;
   assign capActive         = state.active;
   assign appliedCap        = state.cap;

endmodule // servo_speed_cap_select

/* design/servo_cap_pkg.sv */
// Package: register map, field layout, mode codes and carriers for the speed cap block
//
// How it works
// - Source select 0 always uses cap one
// - Source select 1: switch bit picks cap
// - Cap limits speed in cyclic torque mode only, setting clamped to 20000
// - Applied cap is smallest of four limits
// - Active cap replaces host torque with regulator
// - Full-closed loop only in position modes
// - Velocity/torque cyclic command in full-closed faults
// - Gear 1/1: command unit equals scale count
// - Full-closed: encoder velocity, scale position feedback
// - Both caps reset to zero
package servo_cap_pkg;

   // Bus geometry
   localparam int unsigned DATA_W  = 32;
   localparam int unsigned ADDR_W  = 8;
   localparam int unsigned SPEED_W = 16;

   // Register byte offsets
   localparam logic [ADDR_W-1:0] OFS_CONTROL = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_CAP_ONE = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_CAP_TWO = 8'h08;
   localparam logic [ADDR_W-1:0] OFS_OVS_ONE = 8'h0c;
   localparam logic [ADDR_W-1:0] OFS_OVS_TWO = 8'h10;
   localparam logic [ADDR_W-1:0] OFS_STATUS  = 8'h14;
   localparam logic [ADDR_W-1:0] OFS_FAULT   = 8'h18;

   // Control register fields
   localparam int unsigned CTRL_SOURCE_BIT = 0;
   localparam int unsigned CTRL_FCLOSE_BIT = 1;

   // Status register fields
   localparam int unsigned STAT_FAULT_BIT  = 0;
   localparam int unsigned STAT_ACTIVE_BIT = 1;
   localparam int unsigned STAT_FCLOSE_BIT = 2;
   localparam int unsigned STAT_MODE_LSB   = 4;
   localparam int unsigned STAT_CAP_LSB    = 16;

   // Speed settings in r/min
   localparam logic [SPEED_W-1:0] CAP_MAX     = 16'h4e20;
   localparam logic [SPEED_W-1:0] CAP_RESET   = 16'h0000;
   localparam logic [SPEED_W-1:0] OVS_RESET   = 16'h4e20;

   // Cyclic command mode codes (upper nibble)
   localparam logic [3:0] CODE_PP = 4'h1;
   localparam logic [3:0] CODE_CP = 4'h2;
   localparam logic [3:0] CODE_CV = 4'h3;
   localparam logic [3:0] CODE_CT = 4'h4;

   // Command fault code fields
   localparam logic [7:0] FAULT_MAIN   = 8'h5b;
   localparam logic [3:0] FAULT_SUB    = 4'h1;
   localparam logic [3:0] FAULT_DETAIL = 4'h0;

   // Control modes held by the drive
   typedef enum logic [2:0] {
      MODE_IDLE,
      MODE_PROFILE_POS,
      MODE_CYCLIC_POS,
      MODE_CYCLIC_VEL,
      MODE_CYCLIC_TRQ
   } ctrl_mode_t;

   // APB request bundle from the master
   typedef struct packed {
      logic              psel;
      logic              penable;
      logic              pwrite;
      logic [ADDR_W-1:0] paddr;
      logic [DATA_W-1:0] pwdata;
   } apb_req_t;

   // Unsigned magnitude of a signed speed
   function automatic logic [SPEED_W-1:0] speedMagnitude(input logic signed [SPEED_W-1:0] s);
      return s[SPEED_W-1] ? SPEED_W'(-s) : SPEED_W'(s);
   endfunction

endpackage

/* design/speed_cap_regulator.sv */
// Speed regulator that takes over the torque command while the cap is active
module speed_cap_regulator
   import servo_cap_pkg::*;
#(
   parameter int unsigned KP_SHIFT = 4           // Proportional gain as a left shift
) (
   input  wire logic                               clk,
   input  wire logic                               rstSyncB,
   input  wire logic                               capActive,
   input  wire logic        [servo_cap_pkg::SPEED_W-1:0] cap,
   input  wire logic signed [servo_cap_pkg::SPEED_W-1:0] motorSpeed,
   input  wire logic signed [servo_cap_pkg::SPEED_W-1:0] hostTorque,
   output      logic signed [servo_cap_pkg::SPEED_W-1:0] motorTorque
);
   import servo_cap_pkg::*;

   // Gain shift beyond this overflows the working width
   if (KP_SHIFT > 8) begin : gainCheck
      $error("KP_SHIFT too large");
   end

   typedef struct packed {
      logic signed [SPEED_W-1:0] torque;         // Torque sent to the motor
   } reg_state_t;

   reg_state_t               state;              // Registered state
   reg_state_t               next_state;         // Next state
   logic signed [17:0]       speedError;         // Cap minus speed magnitude
   logic signed [25:0]       scaled;             // Error times gain
   logic signed [SPEED_W-1:0] regulated;         // Saturated regulator output

   // Regulator and command override
   always_comb begin
      next_state = state;
      speedError = $signed({2'b00, cap}) - $signed({2'b00, speedMagnitude(motorSpeed)});
      scaled     = 26'(speedError) <<< KP_SHIFT;
      if (scaled > 26'sd32767) begin
         regulated = 16'sh7fff;                  // Saturate high
      end else if (scaled < -26'sd32767) begin
         regulated = -16'sh7fff;                 // Saturate low
      end else begin
         regulated = scaled[SPEED_W-1:0];
      end
      // Drive speed toward cap in the host's direction
      if (hostTorque < 0) begin
         regulated = -regulated;
      end
      next_state.torque = capActive ? regulated : hostTorque;
   end

   // State register
   always_ff @(posedge clk or negedge rstSyncB) begin
      if (!rstSyncB) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end

   assign motorTorque = state.torque;

endmodule // speed_cap_regulator

/* verification/servo_cap_props.sv */
// Checker: cap bound and engage timing, command guard and feedback timing
module servo_cap_props
   import servo_cap_pkg::*;
#(
   parameter logic [15:0] INTERNAL_OVS = 16'h4e20 // Internal overspeed level
) (
   input wire logic                      clk,
   input wire logic                      rst_b,
   input wire logic                      cmdValid,
   input wire logic        [7:0]         cmdCode,
   input wire logic signed [15:0]        hostTorque,
   input wire logic signed [15:0]        motorSpeed,
   input wire logic signed [15:0]        motorTorque,
   input wire logic signed [15:0]        velocityFeedback,
   input wire servo_cap_pkg::ctrl_mode_t controlMode,
   input wire logic                      command_fault,
   input wire logic        [15:0]        faultCode,
   input wire logic                      capActive,
   input wire logic        [15:0]        appliedCap
);
   logic [2:0]  upSeq;     // Edges seen since reset release
   logic [15:0] spdMag;    // Speed magnitude
   logic        refuseReq; // Velocity or torque command
   logic        wantCap;   // Cap should engage
   // Wait three edges after reset before checking
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         upSeq <= 3'h0;
      end else begin
         upSeq <= {upSeq[1:0], 1'b1};
      end
   end
   // Magnitude and engage condition
   always_comb begin
      spdMag    = motorSpeed[15] ? 16'(-motorSpeed) : 16'(motorSpeed);
      refuseReq = cmdValid && (cmdCode[7:4] == CODE_CV || cmdCode[7:4] == CODE_CT);
      wantCap   = controlMode == MODE_CYCLIC_TRQ && spdMag >= appliedCap;
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!upSeq[2]);
   // Position mode command
   sequence posCmd;
      cmdValid && (cmdCode[7:4] == CODE_PP || cmdCode[7:4] == CODE_CP);
   endsequence
   // Velocity or torque mode command
   sequence velTrqCmd;
      refuseReq;
   endsequence
   mode_take_a: assert property (posCmd |=> controlMode == $past(cmdCode[6:4]))
      else $error("position command not taken");
   refuse_take_a: assert property (velTrqCmd |=> command_fault || controlMode == $past(cmdCode[6:4]))
      else $error("velocity or torque command neither taken nor refused");
   fault_cause_a: assert property ($rose(command_fault) |-> $past(refuseReq))
      else $error("fault without refused command");
   fault_code_a: assert property (faultCode == (command_fault ? 16'h5b10 : 16'h0000))
      else $error("fault code wrong");
   cap_bound_a: assert property (appliedCap <= INTERNAL_OVS && appliedCap <= 16'h4e20)
      else $error("applied cap above limit");
   cap_active_a: assert property (capActive == $past(wantCap))
      else $error("cap engage timing wrong");
   torque_pass_a: assert property (!capActive |=> motorTorque == $past(hostTorque))
      else $error("host torque not passed");
   vel_feed_a: assert property (velocityFeedback == $past(motorSpeed))
      else $error("velocity feedback not from motor speed");
endmodule // servo_cap_props

/* verification/host_ctrl_model.sv */
// Host controller model: cyclic command strobes and the switch bit
module host_ctrl_model (
   input  wire logic       clk,
   output      logic       cmdValid,
   output      logic [7:0] cmdCode,
   output      logic       speed_limit_switch_cmd
);
   timeunit 1ns;
   timeprecision 1ns;
   // Idle from time zero
   initial begin
      cmdValid               = 1'b0;
      cmdCode                = 8'h00;
      speed_limit_switch_cmd = 1'b0;
   end
   // One-cycle command after a pause of zero to two cycles
   task automatic sendCmd(input logic [7:0] code);
      repeat ($urandom_range(2, 0)) @(posedge clk);
      cmdValid <= 1'b1;
      cmdCode  <= code;
      @(posedge clk);
      cmdValid <= 1'b0;
      cmdCode  <= ~code; // No stale code between commands
      @(posedge clk);
   endtask
   // Host level of the switch bit
   task automatic setSwitch(input logic v);
      speed_limit_switch_cmd <= v;
      @(posedge clk);
   endtask
endmodule // host_ctrl_model

/* verification/tb.sv */
// Testbench: reset values, cap choice, cap engage, full-closed guard
module tb;
   import servo_cap_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int unsigned KP = 4; // Regulator gain shift
   logic               clk;               // 10 MHz clock
   logic               rst_b;             // Async reset, low
   apb_req_t           req;               // APB request
   logic        [31:0] prdata;            // Read data
   logic               pready;            // Ready
   logic               pslverr;           // Error
   logic               cmdValid;          // Command strobe
   logic        [7:0]  cmdCode;           // Command code
   logic               speed_limit_switch_cmd; // Switch bit
   logic signed [15:0] hostTorque;        // Host torque
   logic signed [15:0] motorSpeed;        // Motor speed
   logic        [31:0] motorPosition;     // Encoder position
   logic        [31:0] scalePosition;     // Scale position
   logic        [31:0] positionCommand;   // Position command
   logic signed [15:0] motorTorque;       // Torque out
   logic        [31:0] positionFeedback;  // Position out
   logic        [31:0] positionReference; // Reference out
   logic        [32:0] expQ[$];           // Expected read notes
   logic        [15:0] c1, c2, o1, o2, cap; // Cap settings
   int                 checks;            // Comparisons
   int                 n_fail;            // Mismatches
   int                 i;                 // Loop index
   // 100 ns clock
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   servo_speed_cap_select #(.KP_SHIFT(KP)) dut (
      .clk(clk), .rst_b(rst_b), .apbReq(req), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .cmdValid(cmdValid), .cmdCode(cmdCode), .speed_limit_switch_cmd(speed_limit_switch_cmd),
      .hostTorque(hostTorque), .motorSpeed(motorSpeed), .motorPosition(motorPosition),
      .scalePosition(scalePosition), .positionCommand(positionCommand), .motorTorque(motorTorque),
      .velocityFeedback(), .positionFeedback(positionFeedback), .positionReference(positionReference),
      .controlMode(), .command_fault(), .faultCode(), .capActive(), .appliedCap());
   host_ctrl_model host (.clk(clk), .cmdValid(cmdValid), .cmdCode(cmdCode),
      .speed_limit_switch_cmd(speed_limit_switch_cmd));
   // Compare and count
   task automatic chk(input string what, input logic [32:0] exp, input logic [32:0] got);
      checks++;
      if (got !== exp) begin
         n_fail++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask
   // Counts, verdict, end
   task automatic final_report;
      $display("checks=%0d n_fail=%0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   // One APB transfer, held until ready
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
      @(posedge clk);
      req.penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) @(posedge clk);
      req.psel    <= 1'b0;
      req.penable <= 1'b0;
      @(posedge clk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   // Read with noted error flag and data
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      expQ.push_back({a > OFS_FAULT, e});
      apb(1'b0, a, 32'h0);
   endtask
   // Status word layout
   function automatic logic [31:0] stat(input logic [15:0] c, input logic [2:0] m, input logic f, a, e);
      return {c, 9'h0, m, 1'b0, f, a, e};
   endfunction
   // Oldest note against each completed read
   always @(posedge clk) begin
      if (req.psel === 1'b1 && req.penable === 1'b1 && pready === 1'b1 && req.pwrite === 1'b0) begin
         chk("apb read", expQ.pop_front(), {pslverr, prdata});
      end
   end
   // Main sequence
   initial begin
      req             = '0;
      rst_b           = 1'b0;
      hostTorque      = 16'h0000;
      motorSpeed      = 16'h0000;
      motorPosition   = 32'h0;
      scalePosition   = 32'h0;
      positionCommand = 32'h0;
      void'($urandom(39));
      repeat (10) @(posedge clk);
      rst_b <= 1'b1;
      repeat (3) @(posedge clk);
      rd(OFS_CAP_ONE, 32'h0);
      rd(OFS_CAP_TWO, 32'h0);
      rd(OFS_OVS_ONE, 32'h4e20);
      rd(8'h1c, 32'h0);
      wr(OFS_CAP_ONE, 32'h5000);
      rd(OFS_CAP_ONE, 32'h4e20);
      c1 = 16'($urandom_range(19999, 200));
      c2 = 16'($urandom_range(19999, 200));
      o1 = 16'($urandom_range(19999, 200));
      o2 = 16'($urandom_range(19999, 200));
      wr(OFS_CAP_ONE, {16'h0, c1});
      wr(OFS_CAP_TWO, {16'h0, c2});
      wr(OFS_OVS_ONE, {16'h0, o1});
      wr(OFS_OVS_TWO, {16'h0, o2});
      host.sendCmd({CODE_CT, 4'h0});
      // Each source setting with each switch level
      for (i = 0; i < 4; i++) begin
         wr(OFS_CONTROL, 32'(i >> 1));
         host.setSwitch(i[0]);
         cap = (i == 3) ? c2 : c1;
         cap = (cap < o1) ? cap : o1;
         cap = (cap < o2) ? cap : o2;
         repeat (3) @(posedge clk);
         rd(OFS_STATUS, stat(cap, MODE_CYCLIC_TRQ, 1'b0, 1'b0, 1'b0));
      end
      // Reverse speed past the cap engages the regulator
      hostTorque <= 16'h0064;
      motorSpeed <= 16'(-(int'(cap) + 5));
      repeat (4) @(posedge clk);
      @(negedge clk);
      chk("motorTorque", {17'h0, 16'(-(5 << KP))}, {17'h0, motorTorque});
      @(posedge clk);
      rd(OFS_STATUS, stat(cap, MODE_CYCLIC_TRQ, 1'b0, 1'b1, 1'b0));
      motorSpeed <= 16'(cap - 16'h1);
      repeat (3) @(posedge clk);
      @(negedge clk);
      chk("motorTorque", 33'h64, {17'h0, motorTorque});
      @(posedge clk);
      motorSpeed <= 16'h0000;
      wr(OFS_CONTROL, 32'h3);
      // Position modes taken, velocity and torque refused
      for (i = 1; i < 5; i++) begin
         host.sendCmd(8'(i << 4));
         repeat (2) @(posedge clk);
         rd(OFS_STATUS, stat(cap, (i < 3) ? 3'(i) : 3'h2, 1'b1, 1'b0, 1'(i > 2)));
         rd(OFS_FAULT, (i > 2) ? 32'h5b10 : 32'h0);
         wr(OFS_STATUS, 32'h1);
      end
      motorPosition   <= $urandom;
      scalePosition   <= $urandom;
      positionCommand <= $urandom;
      repeat (2) @(posedge clk);
      @(negedge clk);
      chk("positionFeedback", {1'b0, scalePosition}, {1'b0, positionFeedback});
      chk("positionReference", {1'b0, positionCommand}, {1'b0, positionReference});
      // Leaving the full-closed loop returns to encoder position
      @(posedge clk);
      wr(OFS_CONTROL, 32'h1);
      @(negedge clk);
      chk("positionFeedback", {1'b0, motorPosition}, {1'b0, positionFeedback});
      final_report();
   end
   // Cuts a hang short
   initial begin
      repeat (3000) @(posedge clk);
      n_fail++;
      final_report();
   end
endmodule // tb
bind servo_speed_cap_select servo_cap_props #(.INTERNAL_OVS(INTERNAL_OVS)) props (
   .clk(clk), .rst_b(rst_b), .cmdValid(cmdValid), .cmdCode(cmdCode), .hostTorque(hostTorque),
   .motorSpeed(motorSpeed), .motorTorque(motorTorque), .velocityFeedback(velocityFeedback),
   .controlMode(controlMode), .command_fault(command_fault), .faultCode(faultCode),
   .capActive(capActive), .appliedCap(appliedCap));
